// file: verilog/ifeb_pkg.sv
// Package for the interrupt flag and enable bank.
// Assumes an APB slave on a single 40 MHz clock, registers in the low byte.
package ifeb_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte addresses
  localparam logic [7:0] ADDR_EDGE_SEL = 8'h00;
  localparam logic [7:0] ADDR_CTRL0 = 8'h04;
  localparam logic [7:0] ADDR_CTRL1 = 8'h08;
  localparam logic [7:0] ADDR_CTRL2 = 8'h0C;
  localparam logic [7:0] ADDR_TCMP = 8'h10;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h14;
  localparam logic [7:0] ADDR_EVT_MASK = 8'h18;

  // Reset value of every register
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // Source index, lower index wins arbitration
  localparam logic [2:0] SRC_EXT = 3'h0;
  localparam logic [2:0] SRC_MULTI = 3'h1;
  localparam logic [2:0] SRC_TICK0 = 3'h2;
  localparam logic [2:0] SRC_TICK1 = 3'h3;
  localparam logic [2:0] SRC_CONV = 3'h4;
  localparam logic [2:0] SRC_NVM = 3'h5;
  localparam logic [2:0] SRC_SERIAL = 3'h6;
  localparam logic [2:0] SRC_ASYNC = 3'h7;

  // Control register 0 fields
  localparam int C0_TICK0_F = 6;
  localparam int C0_MULTI_F = 5;
  localparam int C0_EXT_F = 4;
  localparam int C0_TICK0_E = 3;
  localparam int C0_MULTI_E = 2;
  localparam int C0_EXT_E = 1;
  localparam int C0_GLOBAL_E = 0;

  // Control register 1 fields
  localparam int C1_SERIAL_F = 7;
  localparam int C1_NVM_F = 6;
  localparam int C1_CONV_F = 5;
  localparam int C1_TICK1_F = 4;
  localparam int C1_SERIAL_E = 3;
  localparam int C1_NVM_E = 2;
  localparam int C1_CONV_E = 1;
  localparam int C1_TICK1_E = 0;

  // Control register 2 fields
  localparam int C2_ASYNC_F = 4;
  localparam int C2_ASYNC_E = 0;

  // Timer compare register: flags high nibble, enables low nibble
  localparam int TCMP_F_LSB = 4;
  localparam int TCMP_E_LSB = 0;

  // External pin edge select
  typedef enum logic [1:0] {
    IFEB_EDGE_OFF = 2'b00,
    IFEB_EDGE_RISE = 2'b01,
    IFEB_EDGE_FALL = 2'b10,
    IFEB_EDGE_BOTH = 2'b11
  } ifeb_edge_t;

endpackage

// file: verilog/ifeb_prio.sv
// Fixed priority picker over the eight interrupt sources.
// Assumes lower index is higher priority; purely combinational.
module ifeb_prio (
  input wire logic [7:0] pending,
  output logic valid,
  output logic [2:0] idx
);
  always_comb
  begin
    valid = 1'b0;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (pending[i])
      begin
        valid = 1'b1;
        idx = 3'(i);
      end
    end
  end
endmodule

// file: verilog/ifeb_top.sv
// Interrupt request flag and enable bank with APB register access.
// Assumes all inputs synchronous to pclk; core pulses irq_ack on service.
//
// Contract
// - Two-bit edge select: off, rising, falling, both; upper six bits zero
// - Control 0 holds tick0/multi/pin flags, their enables, global enable
// - Control 1 holds serial, nvm, conversion, tick1 flags and enables
// - Control 2 holds async serial flag bit 4, enable bit 0, rest zero
// - Timer compare register: four flags high, four enables low
// - Flags show pending, enables gate sources, all clear at reset
// - Hardware sets flags on events; software may write flags and enables
// - Disabled flag stays recorded; global enable low blocks irq_req but not irq_out
// - Servicing clears global enable while new requests still record
// - Servicing any source, the pin included, also clears that source's flag
module ifeb_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ifeb_pkg::ADDR_W-1:0] paddr,
  input wire logic [ifeb_pkg::DATA_W-1:0] pwdata,
  output logic [ifeb_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_pin,
  input wire logic tick0_evt,
  input wire logic tick1_evt,
  input wire logic conv_done_evt,
  input wire logic nvm_write_evt,
  input wire logic serial_if_evt,
  input wire logic async_serial_evt,
  input wire logic [3:0] tcmp_evt,
  input wire logic irq_ack,
  output logic irq_req,
  output logic [2:0] irq_src,
  output logic irq_out
);
  import ifeb_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic [7:0] onehot8(input logic [2:0] i);
    return 8'h01 << i;
  endfunction

  ifeb_edge_t edge_sel;
  logic global_irq_enable, pin_prev, pin_armed, pin_rise, pin_fall;
  logic ext_edge, multi_set, prio_valid, acc, wr_fire, rd_fire;
  logic ack_fire, addr_ok;
  logic [2:0] prio_idx;
  logic [3:0] tcmp_flag, tcmp_en;
  logic [7:0] flag, en, evt_status, evt_mask, next_evt_status, next_evt_mask;
  logic [7:0] hw_set, sw_we, sw_val, en_val, ack_clr, pending, rd_val;

  // Bus phases
  assign acc = psel & penable & ~pready;
  assign wr_fire = psel & penable & pready & pwrite;
  assign rd_fire = psel & penable & pready & ~pwrite;
  assign ack_fire = irq_ack & irq_req;
  assign addr_ok = hit(paddr, ADDR_EDGE_SEL) | hit(paddr, ADDR_CTRL0) |
                   hit(paddr, ADDR_CTRL1) | hit(paddr, ADDR_CTRL2) |
                   hit(paddr, ADDR_TCMP) | hit(paddr, ADDR_EVT_STATUS) |
                   hit(paddr, ADDR_EVT_MASK);

  // Pin edge detection
  assign pin_rise = pin_armed & ext_pin & ~pin_prev;
  assign pin_fall = pin_armed & ~ext_pin & pin_prev;

  always_comb
  begin
    case (edge_sel)
      IFEB_EDGE_OFF: ext_edge = 1'b0;
      IFEB_EDGE_RISE: ext_edge = pin_rise;
      IFEB_EDGE_FALL: ext_edge = pin_fall;
      IFEB_EDGE_BOTH: ext_edge = pin_rise | pin_fall;
      default: ext_edge = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_prev <= 1'b0;
      pin_armed <= 1'b0;
    end
    else
    begin
      pin_prev <= ext_pin;
      pin_armed <= 1'b1;
    end
  end

  // Hardware set sources, bit position is the source index
  assign multi_set = |(tcmp_evt & tcmp_en);
  assign hw_set = {async_serial_evt, serial_if_evt, nvm_write_evt,
    conv_done_evt, tick1_evt, tick0_evt, multi_set, ext_edge};

  // Software write decode for flags and enables
  always_comb
  begin
    sw_we = 8'h00;
    sw_val = 8'h00;
    en_val = 8'h00;
    if (wr_fire && hit(paddr, ADDR_CTRL0))
    begin
      {sw_we[SRC_TICK0], sw_we[SRC_MULTI], sw_we[SRC_EXT]} = 3'h7;
      sw_val[SRC_TICK0] = pwdata[C0_TICK0_F];
      sw_val[SRC_MULTI] = pwdata[C0_MULTI_F];
      sw_val[SRC_EXT] = pwdata[C0_EXT_F];
      en_val[SRC_TICK0] = pwdata[C0_TICK0_E];
      en_val[SRC_MULTI] = pwdata[C0_MULTI_E];
      en_val[SRC_EXT] = pwdata[C0_EXT_E];
    end
    if (wr_fire && hit(paddr, ADDR_CTRL1))
    begin
      {sw_we[SRC_SERIAL], sw_we[SRC_NVM], sw_we[SRC_CONV],
        sw_we[SRC_TICK1]} = 4'hF;
      sw_val[SRC_SERIAL] = pwdata[C1_SERIAL_F];
      sw_val[SRC_NVM] = pwdata[C1_NVM_F];
      sw_val[SRC_CONV] = pwdata[C1_CONV_F];
      sw_val[SRC_TICK1] = pwdata[C1_TICK1_F];
      en_val[SRC_SERIAL] = pwdata[C1_SERIAL_E];
      en_val[SRC_NVM] = pwdata[C1_NVM_E];
      en_val[SRC_CONV] = pwdata[C1_CONV_E];
      en_val[SRC_TICK1] = pwdata[C1_TICK1_E];
    end
    if (wr_fire && hit(paddr, ADDR_CTRL2))
    begin
      sw_we[SRC_ASYNC] = 1'b1;
      sw_val[SRC_ASYNC] = pwdata[C2_ASYNC_F];
      en_val[SRC_ASYNC] = pwdata[C2_ASYNC_E];
    end
  end

  // Serviced source flag clear
  assign ack_clr = ack_fire ? onehot8(irq_src) : 8'h00;

  // Request flags and enables: hardware set wins over any clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag <= REG_RESET;
      en <= REG_RESET;
    end
    else
    begin
      flag <= hw_set | (((sw_we & sw_val) | (~sw_we & flag)) & ~ack_clr);
      en <= (sw_we & en_val) | (~sw_we & en);
    end
  end

  // Global enable, cleared by service
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      global_irq_enable <= 1'b0;
    else if (ack_fire)
      global_irq_enable <= 1'b0;
    else if (wr_fire && hit(paddr, ADDR_CTRL0))
      global_irq_enable <= pwdata[C0_GLOBAL_E];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      edge_sel <= IFEB_EDGE_OFF;
    else if (wr_fire && hit(paddr, ADDR_EDGE_SEL))
      edge_sel <= ifeb_edge_t'(pwdata[1:0]);
  end

  // Timer compare flags and enables
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tcmp_flag <= 4'h0;
      tcmp_en <= 4'h0;
    end
    else if (wr_fire && hit(paddr, ADDR_TCMP))
    begin
      tcmp_flag <= tcmp_evt | pwdata[TCMP_F_LSB +: 4];
      tcmp_en <= pwdata[TCMP_E_LSB +: 4];
    end
    else
      tcmp_flag <= tcmp_evt | tcmp_flag;
  end

  // Sticky event status, read clears, new event wins
  always_comb
  begin
    next_evt_status = evt_status;
    next_evt_mask = evt_mask;
    if (rd_fire && hit(paddr, ADDR_EVT_STATUS))
      next_evt_status = 8'h00;
    if (wr_fire && hit(paddr, ADDR_EVT_MASK))
      next_evt_mask = pwdata[7:0];
    next_evt_status = next_evt_status | hw_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt_status <= REG_RESET;
      evt_mask <= REG_RESET;
      irq_out <= 1'b0;
    end
    else
    begin
      evt_status <= next_evt_status;
      evt_mask <= next_evt_mask;
      irq_out <= |(next_evt_status & next_evt_mask);
    end
  end

  // Vector request toward the core
  assign pending = flag & en & {8{global_irq_enable}};

  ifeb_prio u_prio (
    .pending(pending),
    .valid(prio_valid),
    .idx(prio_idx)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_req <= 1'b0;
      irq_src <= 3'h0;
    end
    else
    begin
      irq_req <= prio_valid & ~ack_fire;
      irq_src <= prio_idx;
    end
  end

  // Read data mux
  always_comb
  begin
    rd_val = 8'h00;
    case (paddr)
      ADDR_EDGE_SEL: rd_val = {6'h00, edge_sel};
      ADDR_CTRL0: rd_val = {1'b0, flag[SRC_TICK0], flag[SRC_MULTI],
        flag[SRC_EXT], en[SRC_TICK0], en[SRC_MULTI], en[SRC_EXT],
        global_irq_enable};
      ADDR_CTRL1: rd_val = {flag[SRC_SERIAL], flag[SRC_NVM], flag[SRC_CONV],
        flag[SRC_TICK1], en[SRC_SERIAL], en[SRC_NVM], en[SRC_CONV],
        en[SRC_TICK1]};
      ADDR_CTRL2: rd_val = {3'h0, flag[SRC_ASYNC], 3'h0, en[SRC_ASYNC]};
      ADDR_TCMP: rd_val = {tcmp_flag, tcmp_en};
      ADDR_EVT_STATUS: rd_val = evt_status;
      ADDR_EVT_MASK: rd_val = evt_mask;
      default: rd_val = 8'h00;
    endcase
  end

  // APB answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= RDATA_ZERO;
    end
    else
    begin
      pready <= acc;
      if (acc)
      begin
        pslverr <= ~addr_ok;
        prdata <= {24'h00_0000, rd_val};
      end
      else
        pslverr <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_edge_rise_sets: assert property (
    edge_sel == IFEB_EDGE_RISE && pin_rise |=> flag[SRC_EXT])
    else $error("rising edge did not set pin flag");
  chk_edge_off_quiet: assert property (
    edge_sel == IFEB_EDGE_OFF && !(wr_fire && hit(paddr, ADDR_CTRL0)) &&
    !flag[SRC_EXT] |=> !flag[SRC_EXT])
    else $error("pin flag set while source disabled");
  chk_ctrl0_top_zero: assert property (
    acc && hit(paddr, ADDR_CTRL0) |=> prdata[31:7] == 25'h000_0000 &&
    prdata[0] == $past(global_irq_enable))
    else $error("control 0 readback wrong");
  chk_ctrl2_gaps_zero: assert property (
    acc && hit(paddr, ADDR_CTRL2) |=> prdata[7:5] == 3'h0 &&
    prdata[3:1] == 3'h0)
    else $error("control 2 unimplemented bits not zero");
  chk_event_sets_flag: assert property (
    conv_done_evt |=> flag[SRC_CONV])
    else $error("event lost");
  chk_tcmp_flag_set: assert property (
    tcmp_evt[0] && tcmp_en[0] |=> tcmp_flag[0] && flag[SRC_MULTI])
    else $error("timer compare flag not set");
  chk_global_blocks: assert property (
    !global_irq_enable |=> !irq_req)
    else $error("request while globally disabled");
  chk_ack_clears_global: assert property (
    ack_fire |=> !global_irq_enable ##1 !irq_req)
    else $error("service did not clear global enable");
  chk_ack_clears_pin: assert property (
    ack_fire && irq_src == SRC_EXT && !ext_edge |=> !flag[SRC_EXT])
    else $error("pin flag kept after service");
  chk_prio_order: assert property (
    pending[SRC_EXT] && pending[SRC_ASYNC] && !ack_fire |=>
    irq_src == SRC_EXT && irq_req)
    else $error("priority order broken");
  chk_status_irq: assert property (
    irq_out == |(evt_status & evt_mask))
    else $error("interrupt output low with unmasked status");

  cov_pin_service: cover property (
    irq_req && irq_src == SRC_EXT ##1 ack_fire);
  cov_both_edges: cover property (
    edge_sel == IFEB_EDGE_BOTH && pin_fall);
  cov_status_read_clear: cover property (
    rd_fire && hit(paddr, ADDR_EVT_STATUS) && evt_status != 8'h00);
endmodule

// file: testbench/ifeb_core_model.sv
// Core sequencer model that services interrupt requests.
// Assumes irq_req and irq_src are registered on pclk.
module ifeb_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ack_en,
  input wire logic [3:0] ack_delay,
  input wire logic irq_req,
  input wire logic [2:0] irq_src,
  output logic irq_ack,
  output logic [2:0] last_src,
  output logic [7:0] ack_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_cnt <= 4'h0;
      irq_ack <= 1'b0;
      last_src <= 3'h0;
      ack_cnt <= 8'h00;
    end
    else if (irq_ack)
    begin
      irq_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end
    else if (ack_en && irq_req && wait_cnt == ack_delay)
    begin
      irq_ack <= 1'b1;
      last_src <= irq_src;
      ack_cnt <= ack_cnt + 8'h01;
    end
    else if (irq_req)
      wait_cnt <= wait_cnt + 4'h1;
    else
      wait_cnt <= 4'h0;
  end
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the interrupt flag and enable bank.
// Assumes the core model above; drives APB and the event inputs.
`define CHK(nm, ex, got) \
  begin \
    check_count++; \
    if ((got) !== (ex)) \
    begin \
      n_mismatch++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
    end \
  end

module testbench;
  import ifeb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic ext_pin, tick0_evt, tick1_evt, conv_done_evt, nvm_write_evt;
  logic serial_if_evt, async_serial_evt, irq_ack, irq_req, irq_out;
  logic ack_en;
  logic [3:0] tcmp_evt, ack_delay;
  logic [2:0] irq_src, last_src;
  logic [7:0] ack_cnt;
  logic [7:0] mr [0:6];
  logic [7:0] wm [0:6] = '{8'h03, 8'h7F, 8'hFF, 8'h11, 8'hFF, 8'h00, 8'hFF};
  int fr [8] = '{1, 1, 1, 2, 2, 2, 2, 3};
  int fb [8] = '{4, 5, 6, 4, 5, 6, 7, 4};
  int n_mismatch = 0;
  int check_count = 0;

  ifeb_top ifeb_top_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_pin, .tick0_evt,
    .tick1_evt, .conv_done_evt, .nvm_write_evt, .serial_if_evt,
    .async_serial_evt, .tcmp_evt, .irq_ack, .irq_req, .irq_src, .irq_out);
  ifeb_core_model ifeb_core_model_inst (.pclk, .presetn, .ack_en,
    .ack_delay, .irq_req, .irq_src, .irq_ack, .last_src, .ack_cnt);

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic summarize();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      summarize();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    mr[a[4:2]] = d & wm[a[4:2]];
    `CHK("wr_err", 1'b0, e)
  endtask

  task automatic rd(input logic [7:0] a);
    logic [31:0] r;
    logic [31:0] x;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    x = {24'h00_0000, mr[a[4:2]]};
    `CHK("rdata", x, r)
    if (a == ADDR_EVT_STATUS)
      mr[5] = 8'h00;
  endtask

  task automatic wait_ack(input logic [7:0] a0);
    int n;
    n = 0;
    while (ack_cnt === a0 && n < 60)
    begin
      @(posedge pclk);
      n++;
    end
    if (ack_cnt === a0)
    begin
      n_mismatch++;
      summarize();
    end
  endtask

  initial
  begin
    repeat (100000) @(posedge pclk);
    n_mismatch++;
    summarize();
  end

  initial
  begin
    logic [31:0] r;
    logic e;
    logic [7:0] ev, m, pend, a0;
    int k;
    {presetn, psel, penable, pwrite, ext_pin, ack_en} = 6'h00;
    {tick0_evt, tick1_evt, conv_done_evt, nvm_write_evt} = 4'h0;
    {serial_if_evt, async_serial_evt, tcmp_evt, ack_delay} = 10'h000;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    for (int i = 0; i < 7; i++) mr[i] = 8'h00;
    void'($urandom(32'h870e));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 7; i++) rd(8'(i * 4));
    apb(1'b1, 8'h1C, 8'hFF, r, e);
    `CHK("wr_unmapped", 1'b1, e)
    apb(1'b0, 8'h1C, 8'h00, r, e);
    `CHK("rd_unmapped", 32'h0000_0000, r)
    for (int i = 0; i < 7; i++)
    begin
      if (i != 5)
      begin
        wr(8'(i * 4), 8'hFF);
        rd(8'(i * 4));
      end
    end
    cyc(2);
    `CHK("req_all", 1'b1, irq_req)
    `CHK("src_all", SRC_EXT, irq_src)
    for (int i = 0; i < 7; i++)
      if (i != 5)
        wr(8'(i * 4), 8'h00);
    // Pin edge modes: rising then falling edge per mode
    for (int md = 0; md < 4; md++)
    begin
      wr(ADDR_EDGE_SEL, 8'(md));
      ext_pin <= 1'b1;
      cyc(4);
      mr[1][4] = md[0];
      mr[5][0] = mr[5][0] | md[0];
      rd(ADDR_CTRL0);
      wr(ADDR_CTRL0, 8'h00);
      ext_pin <= 1'b0;
      cyc(4);
      mr[1][4] = md[1];
      mr[5][0] = mr[5][0] | md[1];
      rd(ADDR_CTRL0);
      wr(ADDR_CTRL0, 8'h00);
    end
    rd(ADDR_EVT_STATUS);
    wr(ADDR_EDGE_SEL, 8'h01);
    wr(ADDR_TCMP, 8'h0F);
    for (int rn = 0; rn < 4; rn++)
    begin
      ack_en <= 1'b0;
      ack_delay <= 4'(rn * 4);
      ev = 8'($urandom);
      ext_pin <= ev[0];
      tcmp_evt <= {3'b000, ev[1]};
      {async_serial_evt, serial_if_evt, nvm_write_evt, conv_done_evt,
        tick1_evt, tick0_evt} <= ev[7:2];
      @(posedge pclk);
      ext_pin <= 1'b0;
      tcmp_evt <= 4'h0;
      {async_serial_evt, serial_if_evt, nvm_write_evt, conv_done_evt,
        tick1_evt, tick0_evt} <= 6'h00;
      cyc(4);
      for (int j = 0; j < 8; j++)
        if (ev[j])
          mr[fr[j]][fb[j]] = 1'b1;
      mr[4][4] = mr[4][4] | ev[1];
      mr[5] = mr[5] | ev;
      wr(ADDR_CTRL0, mr[1] | 8'h0E);
      wr(ADDR_CTRL1, mr[2] | 8'h0F);
      wr(ADDR_CTRL2, mr[3] | 8'h01);
      cyc(2);
      `CHK("req_no_global", 1'b0, irq_req)
      for (int i = 1; i < 5; i++) rd(8'(i * 4));
      m = 8'($urandom);
      wr(ADDR_EVT_MASK, m);
      cyc(2);
      `CHK("irq_out", |(mr[5] & m), irq_out)
      rd(ADDR_EVT_STATUS);
      cyc(2);
      `CHK("irq_out_clr", 1'b0, irq_out)
      ack_en <= 1'b1;
      pend = ev;
      for (int j = 0; j < 8; j++)
      begin
        if (pend != 8'h00)
        begin
          k = 0;
          while (!pend[k]) k++;
          a0 = ack_cnt;
          wr(ADDR_CTRL0, mr[1] | 8'h01);
          wait_ack(a0);
          `CHK("irq_src", k[2:0], last_src)
          pend[k] = 1'b0;
          mr[fr[k]][fb[k]] = 1'b0;
          mr[1][0] = 1'b0;
          cyc(2);
          for (int i = 1; i < 4; i++) rd(8'(i * 4));
        end
      end
      `CHK("req_idle", 1'b0, irq_req)
    end
    summarize();
  end
endmodule
